/* verilog/fll_ctrl_defs.svh */
// register offsets, field positions, reset values and timing counts of the loop control
`ifndef FLL_CTRL_DEFS_SVH
`define FLL_CTRL_DEFS_SVH

// register byte offsets
`define OFF_CTRL_A      8'h00
`define OFF_CTRL_B      8'h04
`define OFF_VALUE       8'h08
`define OFF_MULT        8'h0C
`define OFF_STATUS      8'h10
`define OFF_SYNC_BUSY   8'h14
`define OFF_INT_STATUS  8'h18
`define OFF_INT_CLEAR   8'h1C
`define OFF_INT_ENABLE  8'h20

// field positions
`define CTRLA_ENABLE_BIT  1
`define CTRLB_MODE_BIT    0
`define CTRLB_WAKE_BIT    1
`define VAL_FINE_LSB      0
`define VAL_COARSE_LSB    10
`define STAT_READY_BIT    0
`define STAT_LOCK_BIT     1
`define STAT_CKC_BIT      2
`define STAT_CKF_BIT      3
`define STAT_OOB_BIT      4
`define SYNC_ENABLE_BIT   1
`define INT_CKC_BIT       0
`define INT_CKF_BIT       1
`define INT_OOB_BIT       2

// reset values
`define MULT_RST          16'h0000
`define COARSE_RST        6'h1F
`define FINE_START        10'h200
`define INT_RST           3'h0

// timing counts in clk cycles
`define SYNC_CYCLES       2'h2
`define READY_CYCLES      3'h4

// tolerances of the frequency error, in output ticks per reference period
`define COARSE_TOL        17'h00010
`define FINE_TOL          17'h00001

`endif

/* verilog/fll_ctrl_pkg.sv */
// types shared by the loop control logic
package fll_ctrl_pkg;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_COARSE = 2'b01,
    ST_FINE   = 2'b10,
    ST_LOCKED = 2'b11
  } loop_state_e;

  typedef struct packed {
    logic [5:0] coarse;
    logic [9:0] fine;
  } trim_s;

  typedef struct packed {
    logic oob;
    logic ckf;
    logic ckc;
  } loop_events_s;

endpackage

/* verilog/freq_locked_loop_control.sv */
// control, trim engine and status of the 48 MHz frequency-locked loop, AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "fll_ctrl_defs.svh"

// Summary of operation
// - out-of-bounds flag sets whenever coarse or fine trim hits a limit while locking.
// - closed loop: loop_ready rises only once fine lock is reached.
// - re-enable ignores stored fine trim, fine search restarts from a fixed start.
// - with lose-lock-after-wake set, lock_status may stay 1 after disable.
// - disabling in closed loop does not clear coarse and fine lock bits.
// - writing mode bit zero clears lock bits; software does so after disabling.
// - status flags are not meaningful while loop registers are being configured.
// - changing lose-lock-after-wake while not stopped corrupts controller and lock status.
module freq_locked_loop_control (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // axi4-lite write address
  input  wire logic [7:0]           awaddr,
  input  wire logic [2:0]           awprot,
  input  wire logic                 awvalid,
  output logic                      awready,
  // axi4-lite write data
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  // axi4-lite write response
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  // axi4-lite read address
  input  wire logic [7:0]           araddr,
  input  wire logic [2:0]           arprot,
  input  wire logic                 arvalid,
  output logic                      arready,
  // axi4-lite read data
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  // oscillator side
  input  wire logic                 ref_tick,
  input  wire logic                 dco_tick,
  output fll_ctrl_pkg::trim_s       trim,
  output logic                      loop_running,
  // interrupt
  output logic                      irq
);
  import fll_ctrl_pkg::*;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `OFF_CTRL_A) || (a == `OFF_CTRL_B) || (a == `OFF_VALUE) ||
              (a == `OFF_MULT) || (a == `OFF_STATUS) || (a == `OFF_SYNC_BUSY) ||
              (a == `OFF_INT_STATUS) || (a == `OFF_INT_CLEAR) || (a == `OFF_INT_ENABLE);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    merge = m;
  endfunction

  function automatic logic [16:0] abs17(input logic [16:0] v);
    abs17 = v[16] ? 17'(~v + 17'h00001) : v;
  endfunction

  // bus side state
  logic              awready_q;
  logic              wready_q;
  logic              aw_held_q;
  logic              w_held_q;
  logic [7:0]        awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;

  // software registers
  logic              enable_q;
  logic              mode_q;
  logic              wake_lock_q;
  logic [15:0]       mult_q;
  logic [2:0]        int_status_q;
  logic [2:0]        int_enable_q;
  logic              irq_q;

  // enable synchronisation
  logic              sync_busy_q;
  logic [1:0]        sync_cnt_q;
  logic              loop_en_q;
  logic              loop_en_prev_q;

  // loop engine
  loop_state_e       state_q;
  trim_s             trim_q;
  logic              ckc_q;
  logic              ckf_q;
  logic              lock_q;
  logic              ready_q;
  logic              oob_q;
  logic [2:0]        ready_cnt_q;
  logic [15:0]       tick_cnt_q;
  logic [15:0]       meas_q;
  logic              meas_valid_q;
  loop_events_s      ev;

  logic              wr_fire;
  logic              wr_ctrla;
  logic              wr_ctrlb;
  logic              wr_value;
  logic              wr_mult;
  logic              wr_clear;
  logic              wr_inten;
  logic [31:0]       ctrlb_new;
  logic [31:0]       value_new;
  logic [31:0]       mult_new;
  logic [31:0]       ctrla_new;
  logic [31:0]       rd_mux;
  logic [16:0]       err;
  logic [16:0]       err_abs;
  logic              loop_rise;
  logic              loop_fall;
  logic              wake_change;

  assign wr_fire   = aw_held_q && w_held_q && !bvalid_q;
  assign wr_ctrla  = wr_fire && (awaddr_q == `OFF_CTRL_A);
  assign wr_ctrlb  = wr_fire && (awaddr_q == `OFF_CTRL_B);
  assign wr_value  = wr_fire && (awaddr_q == `OFF_VALUE);
  assign wr_mult   = wr_fire && (awaddr_q == `OFF_MULT);
  assign wr_clear  = wr_fire && (awaddr_q == `OFF_INT_CLEAR);
  assign wr_inten  = wr_fire && (awaddr_q == `OFF_INT_ENABLE);
  assign ctrla_new = merge(32'(enable_q) << `CTRLA_ENABLE_BIT, wdata_q, wstrb_q);
  assign ctrlb_new = merge({30'h0, wake_lock_q, mode_q}, wdata_q, wstrb_q);
  assign value_new = merge({16'h0, trim_q}, wdata_q, wstrb_q);
  assign mult_new  = merge({16'h0, mult_q}, wdata_q, wstrb_q);

  assign err       = 17'({1'b0, meas_q} - {1'b0, mult_q});
  assign err_abs   = abs17(err);
  assign loop_rise = loop_en_q && !loop_en_prev_q;
  assign loop_fall = !loop_en_q && loop_en_prev_q;
  // corruption hazard: bit flipped while loop not fully stopped
  assign wake_change = wr_ctrlb && (ctrlb_new[`CTRLB_WAKE_BIT] != wake_lock_q) &&
                       (loop_en_q || sync_busy_q || ready_q);

  assign awready      = awready_q;
  assign wready       = wready_q;
  assign bvalid       = bvalid_q;
  assign bresp        = bresp_q;
  assign arready      = arready_q;
  assign rvalid       = rvalid_q;
  assign rdata        = rdata_q;
  assign rresp        = rresp_q;
  assign trim         = trim_q;
  assign loop_running = loop_en_q;
  assign irq          = irq_q;

  // write channels, accepted in either order, one write outstanding
  always_ff @(posedge clk) begin
    if (rst) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (awvalid && awready_q) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= awaddr;
        awready_q <= 1'b0;
      end
      if (wvalid && wready_q) begin
        w_held_q <= 1'b1;
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= addr_ok(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (araddr)
      `OFF_CTRL_A:     rd_mux[`CTRLA_ENABLE_BIT] = enable_q;
      `OFF_CTRL_B:     rd_mux[1:0] = {wake_lock_q, mode_q};
      `OFF_VALUE:      rd_mux[15:0] = trim_q;
      `OFF_MULT:       rd_mux[15:0] = mult_q;
      // flags may read stale values while loop registers are being set up
      `OFF_STATUS:     rd_mux[4:0] = {oob_q, ckf_q, ckc_q, lock_q, ready_q};
      `OFF_SYNC_BUSY:  rd_mux[`SYNC_ENABLE_BIT] = sync_busy_q;
      `OFF_INT_STATUS: rd_mux[2:0] = int_status_q;
      `OFF_INT_ENABLE: rd_mux[2:0] = int_enable_q;
      default:         rd_mux = 32'h00000000;
    endcase
  end

  // read channel, one read outstanding
  always_ff @(posedge clk) begin
    if (rst) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= RESP_OKAY;
    end else begin
      if (arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_mux;
        rresp_q   <= addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid_q && rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // control registers
  always_ff @(posedge clk) begin
    if (rst) begin
      enable_q     <= 1'b0;
      mode_q       <= 1'b0;
      wake_lock_q  <= 1'b0;
      mult_q       <= `MULT_RST;
      int_enable_q <= `INT_RST;
    end else begin
      if (wr_ctrla) begin
        enable_q <= ctrla_new[`CTRLA_ENABLE_BIT];
      end
      if (wr_ctrlb) begin
        mode_q <= ctrlb_new[`CTRLB_MODE_BIT];
        wake_lock_q <= ctrlb_new[`CTRLB_WAKE_BIT];
      end
      if (wr_mult) begin
        mult_q <= mult_new[15:0];
      end
      if (wr_inten) begin
        int_enable_q <= wdata_q[2:0];
      end
    end
  end

  // enable crossing into the loop side takes a fixed latency
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_busy_q    <= 1'b0;
      sync_cnt_q     <= 2'h0;
      loop_en_q      <= 1'b0;
      loop_en_prev_q <= 1'b0;
    end else begin
      loop_en_prev_q <= loop_en_q;
      if (wr_ctrla) begin
        sync_busy_q <= 1'b1;
        sync_cnt_q  <= `SYNC_CYCLES;
      end else if (sync_busy_q) begin
        if (sync_cnt_q == 2'h1) begin
          sync_busy_q <= 1'b0;
          loop_en_q   <= enable_q;
        end
        sync_cnt_q <= 2'(sync_cnt_q - 2'h1);
      end
    end
  end

  // frequency measurement: output ticks per reference period
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_q   <= 16'h0000;
      meas_q       <= 16'h0000;
      meas_valid_q <= 1'b0;
    end else begin
      meas_valid_q <= ref_tick && loop_en_q;
      if (ref_tick) begin
        meas_q     <= tick_cnt_q;
        tick_cnt_q <= dco_tick ? 16'h0001 : 16'h0000;
      end else if (dco_tick && tick_cnt_q != 16'hFFFF) begin
        tick_cnt_q <= 16'(tick_cnt_q + 16'h0001);
      end
    end
  end

  // trim engine and loop status
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q     <= ST_IDLE;
      trim_q      <= '{coarse: `COARSE_RST, fine: `FINE_START};
      ckc_q       <= 1'b0;
      ckf_q       <= 1'b0;
      lock_q      <= 1'b0;
      ready_q     <= 1'b0;
      oob_q       <= 1'b0;
      ready_cnt_q <= 3'h0;
      ev          <= '0;
    end else begin
      ev <= '0;
      if (wr_value) begin
        trim_q <= value_new[15:0];
      end
      if (loop_rise) begin
        // stored fine trim discarded, search restarts mid-range
        trim_q.fine <= `FINE_START;
        ready_cnt_q <= `READY_CYCLES;
        state_q     <= mode_q ? ST_COARSE : ST_IDLE;
      end else if (loop_fall) begin
        state_q <= ST_IDLE;
        ready_q <= 1'b0;
        if (!wake_lock_q) begin
          lock_q <= 1'b0;
        end
        if (!mode_q) begin
          ckc_q <= 1'b0;
          ckf_q <= 1'b0;
        end
      end else if (loop_en_q && !mode_q) begin
        state_q <= ST_IDLE;
        if (ready_cnt_q != 3'h0) begin
          ready_cnt_q <= 3'(ready_cnt_q - 3'h1);
        end else begin
          ready_q <= 1'b1;
        end
      end else if (loop_en_q && mode_q && state_q == ST_IDLE) begin
        state_q <= ST_COARSE;
        ready_q <= 1'b0;
      end else if (loop_en_q && meas_valid_q) begin
        unique case (state_q)
          ST_COARSE: begin
            if (err_abs <= `COARSE_TOL) begin
              ckc_q    <= 1'b1;
              ev.ckc   <= !ckc_q;
              state_q  <= ST_FINE;
            end else if (!err[16]) begin
              if (trim_q.coarse == 6'h00) begin
                oob_q  <= 1'b1;
                ev.oob <= 1'b1;
              end else begin
                trim_q.coarse <= 6'(trim_q.coarse - 6'h01);
              end
            end else if (trim_q.coarse == 6'h3F) begin
              oob_q  <= 1'b1;
              ev.oob <= 1'b1;
            end else begin
              trim_q.coarse <= 6'(trim_q.coarse + 6'h01);
            end
          end
          ST_FINE, ST_LOCKED: begin
            if (err_abs <= `FINE_TOL) begin
              if (state_q == ST_FINE) begin
                ckf_q   <= 1'b1;
                ev.ckf  <= !ckf_q;
                lock_q  <= 1'b1;
                ready_q <= 1'b1;
                state_q <= ST_LOCKED;
              end
            end else if (!err[16]) begin
              if (trim_q.fine == 10'h000) begin
                oob_q  <= 1'b1;
                ev.oob <= 1'b1;
              end else begin
                trim_q.fine <= 10'(trim_q.fine - 10'h001);
              end
            end else if (trim_q.fine == 10'h3FF) begin
              oob_q  <= 1'b1;
              ev.oob <= 1'b1;
            end else begin
              trim_q.fine <= 10'(trim_q.fine + 10'h001);
            end
          end
          ST_IDLE: state_q <= ST_COARSE;
        endcase
      end
      // mode zero resets the lock indications, later in order so it wins
      if (wr_ctrlb && !ctrlb_new[`CTRLB_MODE_BIT]) begin
        ckc_q  <= 1'b0;
        ckf_q  <= 1'b0;
        lock_q <= 1'b0;
        oob_q  <= 1'b0;
        if (loop_en_q) begin
          state_q <= ST_IDLE;
        end
      end
      if (wake_change) begin
        ckc_q   <= 1'b0;
        ckf_q   <= 1'b0;
        lock_q  <= 1'b0;
        ready_q <= 1'b0;
        state_q <= ST_COARSE;
      end
    end
  end

  // sticky interrupt flags, a set in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (rst) begin
      int_status_q <= `INT_RST;
      irq_q        <= 1'b0;
    end else begin
      int_status_q <= (int_status_q & ~(wr_clear ? wdata_q[2:0] : 3'h0)) |
                      {ev.oob, ev.ckf, ev.ckc};
      irq_q        <= |(int_status_q & int_enable_q);
    end
  end

endmodule
`default_nettype wire

/* testbench/fll_ctrl_asserts.sv */
// assertion checker for the loop control block, bound to its ports
`timescale 1ns/1ps
`default_nettype none
`include "fll_ctrl_defs.svh"
module fll_ctrl_asserts (
  // clock and reset
  input wire logic                clk,
  input wire logic                rst,
  // register bus
  input wire logic [7:0]          awaddr,
  input wire logic                awvalid,
  input wire logic                awready,
  input wire logic [31:0]         wdata,
  input wire logic                wvalid,
  input wire logic                wready,
  input wire logic                bvalid,
  input wire logic [7:0]          araddr,
  input wire logic                arvalid,
  input wire logic                arready,
  input wire logic [31:0]         rdata,
  input wire logic [1:0]          rresp,
  input wire logic                rvalid,
  // loop side
  input wire fll_ctrl_pkg::trim_s trim,
  input wire logic                loop_running,
  input wire logic                irq
);
  logic [7:0]  wa_q;
  logic [7:0]  ra_q;
  logic [31:0] wd_q;
  logic        bv_q;
  logic        mode_q;

  always_ff @(posedge clk) begin
    if (awvalid && awready) wa_q <= awaddr;
    if (wvalid && wready) wd_q <= wdata;
    if (arvalid && arready) ra_q <= araddr;
  end

  // committed mode, so readiness is judged only in closed loop
  always_ff @(posedge clk) begin
    bv_q <= bvalid;
    if (rst) mode_q <= 1'b0;
    else if (bvalid && !bv_q && wa_q == `OFF_CTRL_B) mode_q <= wd_q[`CTRLB_MODE_BIT];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_reset_state: assert property ($fell(rst) |->
    trim == {`COARSE_RST, `FINE_START} && !loop_running && !irq) else $error("bad reset state");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  a_aw_blocked: assert property (bvalid |-> !awready && !wready) else $error("write not blocked");
  a_read_answer: assert property (arvalid && arready |=> rvalid) else $error("read data late");
  a_ar_blocked: assert property (rvalid |-> !arready) else $error("read not blocked");
  a_unmapped_read: assert property (arvalid && arready && araddr > `OFF_INT_ENABLE |=>
    rresp == 2'h2 && rdata == 32'h0) else $error("unmapped read not refused");
  a_enable_sync: assert property (
    $rose(bvalid) && wa_q == `OFF_CTRL_A |-> ##2 loop_running == wd_q[`CTRLA_ENABLE_BIT])
    else $error("enable not carried to loop side");
  a_fine_restart: assert property (
    $rose(loop_running) |-> ##[0:1] trim.fine == `FINE_START) else $error("fine not restarted");
  a_ready_needs_lock: assert property (
    rvalid && ra_q == `OFF_STATUS && mode_q |-> !rdata[`STAT_READY_BIT] || rdata[`STAT_CKF_BIT])
    else $error("ready before fine lock");

  c_enable: cover property ($rose(loop_running));
  c_irq: cover property ($rose(irq));
  c_ready: cover property (rvalid && ra_q == `OFF_STATUS && rdata[`STAT_READY_BIT]);
endmodule

bind freq_locked_loop_control fll_ctrl_asserts u_chk (.clk, .rst, .awaddr, .awvalid, .awready,
  .wdata, .wvalid, .wready, .bvalid, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
  .trim, .loop_running, .irq);
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the loop control block
`timescale 1ns/1ps
`default_nettype none
`include "fll_ctrl_defs.svh"
module tb;
  import fll_ctrl_pkg::*;
  localparam int PER = 320;
  localparam int LIMIT = 60000;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h0;
  logic [7:0]  araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        ref_tick = 1'b0, dco_tick = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, loop_running, irq;
  logic [1:0]  bresp, rresp, bresp_q, rs;
  logic [31:0] rdata, d;
  trim_s       trim;
  int          fails = 0, samples_checked = 0, cyc = 0, pcnt = 0, ticks;

  freq_locked_loop_control u_dut (.clk, .rst, .awaddr, .awprot(3'h0), .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0),
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .ref_tick, .dco_tick, .trim,
    .loop_running, .irq);

  always #5 clk = ~clk;

  // oscillator stand-in: 8 ticks per coarse step, 1 per fine step, so both tolerances reachable
  always @(posedge clk) begin
    ticks = int'(trim.coarse) * 8 + int'(trim.fine) - 480;
    pcnt <= (pcnt == PER - 1) ? 0 : pcnt + 1;
    ref_tick <= (pcnt == PER - 1);
    dco_tick <= (pcnt < ticks);
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fails = fails + 1;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // handshakes taken at the rising edge, where readies and answers hold their pre-edge values
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic bt;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      bt = bvalid;
      bresp_q = bresp;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bt);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    logic rv;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      rv = rvalid;
      v = rdata;
      r = rresp;
      if (arready) arvalid <= 1'b0;
    end while (!rv);
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a, d, rs);
    chk(d & m, e);
  endtask

  // bounded only by the run's cycle ceiling
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    do rd(a, d, rs); while ((d & m) !== e);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rchk(`OFF_VALUE, 32'hFFFF, 32'h7E00);
    rchk(`OFF_STATUS, 32'h1F, 32'h0);
    rchk(`OFF_INT_STATUS, 32'h7, 32'h0);
    rd(8'h24, d, rs);
    chk({d[31:2], rs}, 32'h2);
    wr(8'h24, 32'h1);
    chk({30'h0, bresp_q}, 32'h2);
    // trim-keeping start-up, then closed loop
    wr(`OFF_MULT, 32'h12C);
    wr(`OFF_CTRL_B, 32'h0);
    wr(`OFF_INT_CLEAR, 32'h7);
    wr(`OFF_CTRL_A, 32'h2);
    wr(`OFF_INT_CLEAR, 32'h7);
    poll(`OFF_SYNC_BUSY, 32'h2, 32'h0);
    chk({31'h0, loop_running}, 32'h1);
    rd(`OFF_VALUE, d, rs);
    wr(`OFF_VALUE, d);
    wr(`OFF_INT_ENABLE, 32'h3);
    wr(`OFF_CTRL_B, 32'h1);
    poll(`OFF_STATUS, 32'h1, 32'h1);
    rchk(`OFF_STATUS, 32'h1F, 32'hF);
    rchk(`OFF_INT_STATUS, 32'h7, 32'h3);
    chk({31'h0, irq}, 32'h1);
    wr(`OFF_INT_ENABLE, 32'h7);
    wr(`OFF_INT_CLEAR, 32'h0);
    rchk(`OFF_INT_STATUS, 32'h7, 32'h3);
    wr(`OFF_INT_CLEAR, 32'h3);
    rchk(`OFF_INT_STATUS, 32'h7, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // wake option flipped while running
    wr(`OFF_CTRL_B, 32'h3);
    rchk(`OFF_STATUS, 32'hF, 32'h0);
    poll(`OFF_STATUS, 32'h1, 32'h1);
    wr(`OFF_CTRL_A, 32'h0);
    poll(`OFF_SYNC_BUSY, 32'h2, 32'h0);
    rchk(`OFF_STATUS, 32'h1F, 32'hE);
    wr(`OFF_CTRL_B, 32'h0);
    rchk(`OFF_STATUS, 32'h1F, 32'h0);
    // unreachable target drives coarse to its floor
    wr(`OFF_CTRL_B, 32'h1);
    wr(`OFF_MULT, 32'h0);
    wr(`OFF_INT_CLEAR, 32'h7);
    wr(`OFF_CTRL_A, 32'h2);
    // fine restart lands only once the enable has crossed to the loop side
    poll(`OFF_SYNC_BUSY, 32'h2, 32'h0);
    rchk(`OFF_VALUE, 32'h3FF, 32'h200);
    poll(`OFF_INT_STATUS, 32'h4, 32'h4);
    rchk(`OFF_STATUS, 32'h10, 32'h10);
    chk({26'h0, trim.coarse}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    wr(`OFF_CTRL_A, 32'h0);
    wr(`OFF_CTRL_B, 32'h0);
    rchk(`OFF_STATUS, 32'h1F, 32'h0);
    wr(`OFF_INT_CLEAR, 32'h7);
    rchk(`OFF_INT_STATUS, 32'h7, 32'h0);
    chk({31'h0, irq}, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
